// ===== hdl/crs_pkg.sv
package crs_pkg;

  // register port geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_POWER_MGMT_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;

  // start-up timing, in reference clock cycles
  localparam int unsigned LOCK_CYCLES = 4096;
  localparam int unsigned CNT_W = 13;
  // strap capture waits until the pin synchroniser is full
  localparam logic [CNT_W-1:0] STRAP_CAPTURE_CNT = 13'h0002;

  // ratio strap encodings
  localparam logic [1:0] STRAP_3X = 2'h0;
  localparam logic [1:0] STRAP_16X = 2'h1;
  localparam logic [1:0] STRAP_8X = 2'h2;
  localparam logic [1:0] STRAP_RSVD = 2'h3;

  // multiplier values loaded from the strap, and the divider reset value
  localparam logic [5:0] MULT_3X = 6'h03;
  localparam logic [5:0] MULT_16X = 6'h10;
  localparam logic [5:0] MULT_8X = 6'h08;
  localparam logic [5:0] MULT_BYPASS = 6'h00;
  localparam logic [3:0] DIV_RESET = 4'h1;

  // power management control layout, bit 12 picks the shared pin function
  typedef struct packed {
    logic [18:0] rsvd_hi;
    logic pll_clock_out_sel;
    logic [1:0] rsvd_mid;
    logic [3:0] div;
    logic [5:0] mult;
  } crs_power_mgmt_control_t;

  localparam crs_power_mgmt_control_t POWER_MGMT_CONTROL_RESET = '{
    rsvd_hi: 19'h00000,
    pll_clock_out_sel: 1'b0,
    rsvd_mid: 2'h0,
    div: DIV_RESET,
    mult: MULT_BYPASS
  };

  // status layout
  typedef struct packed {
    logic [22:0] rsvd;
    logic [3:0] tap_state;
    logic tap_reset;
    logic core_run;
    logic clk_sel_pll;
    logic [1:0] strap;
  } crs_status_t;

  // one register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } crs_bus_req_t;

  // start-up sequence
  typedef enum logic [0:0] {
    CRS_LOCK,
    CRS_RUN
  } crs_boot_state_t;

  // test access port controller states
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR,
    TAP_SHIFT_DR, TAP_EXIT1_DR, TAP_PAUSE_DR, TAP_EXIT2_DR,
    TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR,
    TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } crs_tap_state_t;

endpackage

// ===== hdl/crs_top.sv
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/1ps
// Functional notes
// - core clock from pll or reference, per strap
// - strap 00=3:1, 01=16:1, 10=8:1, 11 reserved
// - strap sampled only once at start-up
// - software may reprogram multiplier/divider once the core runs
// - shared pin: reset by default, bit12 selects clock
// - reset mode drives internal core reset out
// - wait 4096 reference cycles, then start core
// - test reset low forces tap reset state
module crs_top #(
  parameter int unsigned LOCK_CYCLES = crs_pkg::LOCK_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [1:0] ratio_select_straps_i,
  input wire logic pll_clk_i,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic trst_n_i,
  input wire logic [crs_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [crs_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [crs_pkg::DATA_W-1:0] reg_rdata_o,
  output logic core_reset_n_o,
  output logic core_start_o,
  output logic core_clk_sel_pll_o,
  output logic [5:0] pll_mult_o,
  output logic [3:0] pll_div_o,
  output logic reset_or_pll_clock_out_o,
  output logic tap_reset_o
);

  // strap ratio to multiplier, zero means run straight from reference
  function automatic logic [5:0] ratio_mult(input logic [1:0] strap);
    logic [5:0] m;
    m = crs_pkg::MULT_BYPASS;
    case (strap)
      crs_pkg::STRAP_3X: m = crs_pkg::MULT_3X;
      crs_pkg::STRAP_16X: m = crs_pkg::MULT_16X;
      crs_pkg::STRAP_8X: m = crs_pkg::MULT_8X;
      default: m = crs_pkg::MULT_BYPASS;
    endcase
    return m;
  endfunction

  // tap controller transition on one tck rise
  function automatic crs_pkg::crs_tap_state_t tap_next(
    input crs_pkg::crs_tap_state_t s,
    input logic tms
  );
    crs_pkg::crs_tap_state_t n;
    n = crs_pkg::TAP_RESET;
    case (s)
      crs_pkg::TAP_RESET: n = tms ? crs_pkg::TAP_RESET : crs_pkg::TAP_IDLE;
      crs_pkg::TAP_IDLE: n = tms ? crs_pkg::TAP_SEL_DR : crs_pkg::TAP_IDLE;
      crs_pkg::TAP_SEL_DR: n = tms ? crs_pkg::TAP_SEL_IR : crs_pkg::TAP_CAP_DR;
      crs_pkg::TAP_CAP_DR: n = tms ? crs_pkg::TAP_EXIT1_DR : crs_pkg::TAP_SHIFT_DR;
      crs_pkg::TAP_SHIFT_DR: n = tms ? crs_pkg::TAP_EXIT1_DR : crs_pkg::TAP_SHIFT_DR;
      crs_pkg::TAP_EXIT1_DR: n = tms ? crs_pkg::TAP_UPD_DR : crs_pkg::TAP_PAUSE_DR;
      crs_pkg::TAP_PAUSE_DR: n = tms ? crs_pkg::TAP_EXIT2_DR : crs_pkg::TAP_PAUSE_DR;
      crs_pkg::TAP_EXIT2_DR: n = tms ? crs_pkg::TAP_UPD_DR : crs_pkg::TAP_SHIFT_DR;
      crs_pkg::TAP_UPD_DR: n = tms ? crs_pkg::TAP_SEL_DR : crs_pkg::TAP_IDLE;
      crs_pkg::TAP_SEL_IR: n = tms ? crs_pkg::TAP_RESET : crs_pkg::TAP_CAP_IR;
      crs_pkg::TAP_CAP_IR: n = tms ? crs_pkg::TAP_EXIT1_IR : crs_pkg::TAP_SHIFT_IR;
      crs_pkg::TAP_SHIFT_IR: n = tms ? crs_pkg::TAP_EXIT1_IR : crs_pkg::TAP_SHIFT_IR;
      crs_pkg::TAP_EXIT1_IR: n = tms ? crs_pkg::TAP_UPD_IR : crs_pkg::TAP_PAUSE_IR;
      crs_pkg::TAP_PAUSE_IR: n = tms ? crs_pkg::TAP_EXIT2_IR : crs_pkg::TAP_PAUSE_IR;
      crs_pkg::TAP_EXIT2_IR: n = tms ? crs_pkg::TAP_UPD_IR : crs_pkg::TAP_SHIFT_IR;
      crs_pkg::TAP_UPD_IR: n = tms ? crs_pkg::TAP_SEL_DR : crs_pkg::TAP_IDLE;
      default: n = crs_pkg::TAP_RESET;
    endcase
    return n;
  endfunction

  // pin synchronisers, stage one feeds stage two only
  logic [1:0] strap_s1_ff;
  logic [1:0] strap_s2_ff;
  logic pll_s1_ff;
  logic pll_s2_ff;
  logic tck_s1_ff;
  logic tck_s2_ff;
  logic tck_d3_ff; // previous synced tck, for edge detect
  logic tms_s1_ff;
  logic tms_s2_ff;
  logic trst_s1_ff;
  logic trst_s2_ff;

  // start-up state
  crs_pkg::crs_boot_state_t boot_ff;
  crs_pkg::crs_boot_state_t nxt_boot;
  logic [crs_pkg::CNT_W-1:0] cnt_ff; // cycles since reset release, held once the core runs
  logic [crs_pkg::CNT_W-1:0] nxt_cnt;
  logic [1:0] strap_ff; // strap caught once after release
  logic [1:0] nxt_strap;
  logic clk_sel_pll_ff;
  logic nxt_clk_sel_pll;
  logic core_start_ff; // one-cycle start pulse
  logic nxt_core_start;

  // control register and pin
  crs_pkg::crs_power_mgmt_control_t power_mgmt_control_ff;
  crs_pkg::crs_power_mgmt_control_t nxt_power_mgmt_control;
  logic pin_ff;
  logic nxt_pin;

  // tap controller
  crs_pkg::crs_tap_state_t tap_ff;
  crs_pkg::crs_tap_state_t nxt_tap;
  logic tap_reset_ff; // flopped so the pin needs no decode after the state flop
  logic nxt_tap_reset;

  // register read path
  logic [crs_pkg::DATA_W-1:0] rdata_ff;
  logic [crs_pkg::DATA_W-1:0] nxt_rdata;

  crs_pkg::crs_bus_req_t req;
  crs_pkg::crs_status_t status;
  logic tck_rise;
  logic lock_done;

  // bundle the register port
  assign req = '{wr: reg_wr_i, rd: reg_rd_i, addr: reg_addr_i, wdata: reg_wdata_i};
  assign tck_rise = tck_s2_ff & ~tck_d3_ff;
  assign lock_done = (cnt_ff == crs_pkg::CNT_W'(LOCK_CYCLES - 1));

  // synchronisers, all pins are outside the reference clock domain
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_s1_ff <= 2'h0;
      strap_s2_ff <= 2'h0;
      pll_s1_ff <= 1'b0;
      pll_s2_ff <= 1'b0;
      tck_s1_ff <= 1'b0;
      tck_s2_ff <= 1'b0;
      tck_d3_ff <= 1'b0;
      tms_s1_ff <= 1'b1;
      tms_s2_ff <= 1'b1;
      trst_s1_ff <= 1'b0;
      trst_s2_ff <= 1'b0;
    end else begin
      strap_s1_ff <= ratio_select_straps_i;
      strap_s2_ff <= strap_s1_ff;
      pll_s1_ff <= pll_clk_i;
      pll_s2_ff <= pll_s1_ff;
      tck_s1_ff <= tck_i;
      tck_s2_ff <= tck_s1_ff;
      tck_d3_ff <= tck_s2_ff;
      tms_s1_ff <= tms_i;
      tms_s2_ff <= tms_s1_ff;
      trst_s1_ff <= trst_n_i;
      trst_s2_ff <= trst_s1_ff;
    end
  end

  // start-up sequence: count the lock interval, catch the strap
  always_comb begin
    nxt_boot = boot_ff;
    nxt_cnt = cnt_ff;
    nxt_strap = strap_ff;
    nxt_clk_sel_pll = clk_sel_pll_ff;
    nxt_core_start = 1'b0;
    case (boot_ff)
      crs_pkg::CRS_LOCK: begin
        nxt_cnt = cnt_ff + crs_pkg::CNT_W'(1);
        // strap read once only, later pin moves are ignored
        if (cnt_ff == crs_pkg::STRAP_CAPTURE_CNT) begin
          nxt_strap = strap_s2_ff;
          // reserved code falls back to the plain reference clock
          nxt_clk_sel_pll = (strap_s2_ff != crs_pkg::STRAP_RSVD);
        end
        // core leaves reset only after the full lock wait
        if (lock_done) begin
          nxt_boot = crs_pkg::CRS_RUN;
          nxt_core_start = 1'b1;
        end
      end
      crs_pkg::CRS_RUN: begin
        nxt_boot = crs_pkg::CRS_RUN; // only the reset input leaves here
      end
      default: begin
        nxt_boot = crs_pkg::CRS_LOCK;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      boot_ff <= crs_pkg::CRS_LOCK;
      cnt_ff <= '0;
      strap_ff <= 2'h0;
      clk_sel_pll_ff <= 1'b0;
      core_start_ff <= 1'b0;
    end else begin
      boot_ff <= nxt_boot;
      cnt_ff <= nxt_cnt;
      strap_ff <= nxt_strap;
      clk_sel_pll_ff <= nxt_clk_sel_pll;
      core_start_ff <= nxt_core_start;
    end
  end

  // control register and shared pin
  always_comb begin
    nxt_power_mgmt_control = power_mgmt_control_ff;
    // the strap seeds the multiplier at start-up
    if (boot_ff == crs_pkg::CRS_LOCK && cnt_ff == crs_pkg::STRAP_CAPTURE_CNT) begin
      nxt_power_mgmt_control.mult = ratio_mult(strap_s2_ff);
    end
    // software owns the fields once the core runs
    if (boot_ff == crs_pkg::CRS_RUN && req.wr && req.addr == crs_pkg::OFS_POWER_MGMT_CONTROL) begin
      nxt_power_mgmt_control = req.wdata;
      nxt_power_mgmt_control.rsvd_hi = '0; // reserved bits stay zero
      nxt_power_mgmt_control.rsvd_mid = '0;
    end
    // pin carries reset unless bit 12 picks the clock
    if (power_mgmt_control_ff.pll_clock_out_sel) begin
      nxt_pin = pll_s2_ff; // sampled copy, coarse against a fast pll
    end else begin
      // active-low core reset, low through the whole lock wait
      nxt_pin = (boot_ff == crs_pkg::CRS_RUN);
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      power_mgmt_control_ff <= crs_pkg::POWER_MGMT_CONTROL_RESET;
      pin_ff <= 1'b0;
    end else begin
      power_mgmt_control_ff <= nxt_power_mgmt_control;
      pin_ff <= nxt_pin;
    end
  end

  // tap controller, stepped on synced tck rises
  always_comb begin
    nxt_tap = tap_ff;
    if (!trst_s2_ff) begin
      nxt_tap = crs_pkg::TAP_RESET; // test reset low wins
    end else if (tck_rise) begin
      nxt_tap = tap_next(tap_ff, tms_s2_ff);
    end
    // decoded from the next state, so it moves in step with the state flop
    nxt_tap_reset = (nxt_tap == crs_pkg::TAP_RESET);
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tap_ff <= crs_pkg::TAP_RESET;
      tap_reset_ff <= 1'b1;
    end else begin
      tap_ff <= nxt_tap;
      tap_reset_ff <= nxt_tap_reset;
    end
  end

  // status view of the block's own state
  always_comb begin
    status = '0;
    status.strap = strap_ff;
    status.clk_sel_pll = clk_sel_pll_ff;
    status.core_run = (boot_ff == crs_pkg::CRS_RUN);
    status.tap_reset = (tap_ff == crs_pkg::TAP_RESET);
    status.tap_state = tap_ff;
  end

  // read data valid the cycle after the strobe, zero otherwise
  always_comb begin
    nxt_rdata = '0;
    if (req.rd) begin
      if (req.addr == crs_pkg::OFS_POWER_MGMT_CONTROL) begin
        nxt_rdata = power_mgmt_control_ff;
      end else if (req.addr == crs_pkg::OFS_STATUS) begin
        nxt_rdata = status;
      end else begin
        nxt_rdata = '0; // unmapped reads as zero
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // outputs straight from flops
  assign reg_rdata_o = rdata_ff;
  assign core_reset_n_o = (boot_ff == crs_pkg::CRS_RUN);
  assign core_start_o = core_start_ff;
  assign core_clk_sel_pll_o = clk_sel_pll_ff;
  assign pll_mult_o = power_mgmt_control_ff.mult;
  assign pll_div_o = power_mgmt_control_ff.div;
  assign reset_or_pll_clock_out_o = pin_ff;
  assign tap_reset_o = tap_reset_ff;

endmodule

// ===== tb/crs_board_model.sv
`timescale 1ns/1ps
// board side stand-in for the analog pll output
module crs_board_model #(
  parameter real HALF_NS = 13.7
) (
  output logic pll_clk_o
);
  // start low so the shared pin never sees an unknown
  initial begin
    pll_clk_o = 1'b0;
  end
  // free running, phase unrelated to the reference clock
  always #(HALF_NS) begin
    pll_clk_o = ~pll_clk_o;
  end
endmodule

// ===== tb/crs_top_checker.sv
`timescale 1ns/1ps
module crs_top_checker #(
  parameter int unsigned LOCK_CYCLES = 4096
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic trst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic core_reset_n_o,
  input wire logic core_start_o,
  input wire logic core_clk_sel_pll_o,
  input wire logic [5:0] pll_mult_o,
  input wire logic [3:0] pll_div_o,
  input wire logic reset_or_pll_clock_out_o,
  input wire logic tap_reset_o
);
  // edges spent in lock, frozen once the core runs
  logic [15:0] lock_cnt_ff;
  logic [15:0] nxt_lock_cnt;
  logic [9:0] wd_low;
  assign wd_low = reg_wdata_i[9:0];
  // next count
  always_comb begin
    nxt_lock_cnt = core_reset_n_o ? lock_cnt_ff : lock_cnt_ff + 16'h0001;
  end
  // count register
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lock_cnt_ff <= 16'h0000;
    end else begin
      lock_cnt_ff <= nxt_lock_cnt;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  a_start_at_lock: assert property (core_start_o |-> lock_cnt_ff == LOCK_CYCLES)
    else $error("core start off the lock count");
  a_no_late_start: assert property (!core_reset_n_o |-> lock_cnt_ff < LOCK_CYCLES)
    else $error("core still held past the lock count");
  a_start_one_cycle: assert property (core_start_o |=> !core_start_o)
    else $error("start pulse too long");
  a_start_with_run: assert property ($rose(core_reset_n_o) |-> core_start_o)
    else $error("core ran without a start pulse");
  a_pin_held_reset: assert property (!core_reset_n_o |-> !reset_or_pll_clock_out_o)
    else $error("shared pin released during lock");
  a_pin_after_start: assert property (core_start_o |=> reset_or_pll_clock_out_o)
    else $error("shared pin not released after start");
  a_wr_refused: assert property (reg_wr_i && !core_reset_n_o |=> $stable(pll_div_o))
    else $error("write taken before the core ran");
  a_wr_applied: assert property (reg_wr_i && core_reset_n_o && reg_addr_i == 8'h00
    |=> {pll_div_o, pll_mult_o} == $past(wd_low)) else $error("multiplier write lost");
  a_strap_frozen: assert property (core_reset_n_o |-> $stable(core_clk_sel_pll_o))
    else $error("clock source moved after start");
  a_trst_to_reset: assert property ($fell(trst_n_i) |-> ##[1:4] tap_reset_o)
    else $error("test reset did not reset the tap");
  c_start: cover property (core_start_o);
  c_tap_reset: cover property ($rose(tap_reset_o));
  c_clock_mode: cover property (core_reset_n_o && $fell(reset_or_pll_clock_out_o));
endmodule
bind crs_top crs_top_checker #(.LOCK_CYCLES(LOCK_CYCLES)) crs_top_checker_inst (.clk_sys_i, .rst_n_i,
  .trst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .core_reset_n_o, .core_start_o, .core_clk_sel_pll_o,
  .pll_mult_o, .pll_div_o, .reset_or_pll_clock_out_o, .tap_reset_o);

// ===== tb/tb_crs_top.sv
`timescale 1ns/1ps
module tb_crs_top;
  localparam int unsigned LOCK = 16; // short lock keeps the run small
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0; // held low from power-up
  logic [1:0] straps = 2'h0;
  logic tck = 1'b0;
  logic tms = 1'b0;
  logic trst_n = 1'b0; // held low after power-up
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [31:0] got;
  logic [31:0] d;
  logic pll_clk, core_reset_n, core_start, clk_sel, pin, tap_reset;
  logic [5:0] mult;
  logic [3:0] div;
  int err_count = 0;
  int compares = 0;
  int cyc = 0;
  int n;
  integer seed = 32'hf0a0310e;
  // reference clock never stops
  always #5 clk_sys_i = ~clk_sys_i;
  crs_board_model crs_board_model_inst (.pll_clk_o(pll_clk));
  crs_top #(.LOCK_CYCLES(LOCK)) crs_top_inst (.clk_sys_i, .rst_n_i, .ratio_select_straps_i(straps),
    .pll_clk_i(pll_clk), .tck_i(tck), .tms_i(tms), .trst_n_i(trst_n), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .core_reset_n_o(core_reset_n),
    .core_start_o(core_start), .core_clk_sel_pll_o(clk_sel), .pll_mult_o(mult), .pll_div_o(div),
    .reset_or_pll_clock_out_o(pin), .tap_reset_o(tap_reset));
  // expected multiplier per strap code
  function automatic logic [5:0] exp_mult(input logic [1:0] s);
    case (s)
      2'h0: return 6'h03;
      2'h1: return 6'h10;
      2'h2: return 6'h08;
      default: return 6'h00;
    endcase
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // one-cycle write strobe
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys_i);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk_sys_i);
    wr <= 1'b0;
    #1;
  endtask
  // read data looked at only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk_sys_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    #1;
    got = rdata;
  endtask
  // tck phases last four cycles, past the synchroniser
  task automatic tck_pulse(input logic m);
    @(posedge clk_sys_i);
    tms <= m;
    repeat (3) @(posedge clk_sys_i);
    tck <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    tck <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic report_and_stop;
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // hang guard, far above the run's length
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      report_and_stop();
    end
  end
  initial begin
    // every strap code, each with its own reset
    for (int s = 0; s < 4; s++) begin
      @(posedge clk_sys_i);
      rst_n_i <= 1'b0;
      straps <= s[1:0];
      repeat (12) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      wr_reg(8'h00, 32'h000013ff); // early write must be dropped
      chk(core_reset_n, 1'b0);
      n = 2;
      while (core_start !== 1'b1 && n < 100) begin
        @(posedge clk_sys_i);
        #1;
        n++;
      end
      chk(n, LOCK);
      chk(div, 4'h1);
      chk(mult, exp_mult(s[1:0]));
      chk(clk_sel, s != 3);
      chk(pin, 1'b0);
      @(posedge clk_sys_i);
      straps <= ~s[1:0]; // late strap change must be ignored
      #1;
      chk(pin, 1'b1);
      chk(core_start, 1'b0);
      chk(core_reset_n, 1'b1);
      // random reprogramming, reserved bits read back zero
      repeat (3) begin
        d = $random(seed);
        wr_reg(8'h00, d);
        chk({div, mult}, d[9:0]);
        rd_reg(8'h00);
        chk(got, d & 32'h000013ff);
      end
      // clock mode must toggle, reset mode must sit high
      wr_reg(8'h00, 32'h00001000);
      n = 0;
      repeat (40) begin
        @(posedge clk_sys_i);
        #1;
        n += pin;
      end
      chk(n > 0 && n < 40, 1'b1);
      wr_reg(8'h00, 32'h00000000);
      repeat (3) @(posedge clk_sys_i);
      #1;
      chk(pin, 1'b1);
      wr_reg(8'h04, 32'hffffffff); // status is read-only
      rd_reg(8'h04);
      chk(got[3:0], {1'b1, s != 3, s[1:0]});
      rd_reg(8'h40);
      chk(got, 32'h00000000);
    end
    // tap held in reset, walked out, then back by tms and by trst
    chk(tap_reset, 1'b1);
    @(posedge clk_sys_i);
    trst_n <= 1'b1;
    tck_pulse(1'b0);
    chk(tap_reset, 1'b0);
    repeat (5) tck_pulse(1'b1);
    chk(tap_reset, 1'b1);
    tck_pulse(1'b0);
    @(posedge clk_sys_i);
    trst_n <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    #1;
    chk(tap_reset, 1'b1);
    report_and_stop();
  end
endmodule
